/* verilog/ufc_channel.sv */
// One serial channel: register port, baud divider, FIFOs, transmitter, receiver, interrupt identification.
// Assumes host strobes and rx are synchronous to clk; the peer channel shares the bus and select lines.
`timescale 1ns/1ps
module ufc_channel (
  input wire logic clk,
  input wire logic reset,
  input wire ufc_pkg::ufc_host_s host,
  input wire logic rx,
  input wire logic modem_event,
  input wire logic general_output_two_n,
  output logic [7:0] rd_data,
  output logic rd_data_oe,
  output logic tx,
  output logic int_out,
  output logic tx_ready_n,
  output logic rx_ready_n,
  output logic multifunction_pin_n,
  output logic concurrent_write
);
  import ufc_pkg::*;

  function automatic logic [4:0] trig_level(input logic [1:0] c);
    case (c)
      2'h0: trig_level = TRIG_1;
      2'h1: trig_level = TRIG_4;
      2'h2: trig_level = TRIG_8;
      default: trig_level = TRIG_14;
    endcase
  endfunction : trig_level

  function automatic logic [3:0] word_bits(input logic [1:0] c);
    word_bits = WL_BASE + {2'h0, c};
  endfunction : word_bits

  logic [3:0] interrupt_enable;
  logic [7:0] line_format_reg, dll, dlm;
  logic fifo_en, dma_sel;
  logic [1:0] trig, afr_mf;
  logic [7:0] txq [16];
  logic [7:0] rxq [16];
  logic [3:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [4:0] tx_count, rx_count;
  ufc_tx_e tx_state;
  ufc_rx_e rx_state;
  logic [5:0] tx_cnt, rx_cnt, stop_len;
  logic [2:0] tx_bit, rx_bit;
  logic [7:0] tx_shift, rx_shift;
  logic rx_prev, rx_done, rx_ferr, overrun, ferr, thre_pend;
  logic [15:0] baud_cnt;
  logic baud_tick, rx_dma_act;
  logic [3:0] to_sub;
  logic [5:0] to_cnt, to_limit;
  logic [2:0] isr_id;
  logic any_pend, ls_src, rda_src, to_src, thre_src, ms_src;
  logic [7:0] lsr_val;

  wire divisor_access_bit = line_format_reg[DIVISOR_ACCESS_BIT_BIT];
  wire [3:0] wl = word_bits(line_format_reg[1:0]);
  wire [15:0] divisor = {dlm, dll};
  wire [2:0] a = host.addr;
  wire [7:0] d = host.data;
  wire this_wr = host.wr & (host.cs | (host.peer_cs & concurrent_write));
  wire rd_go = host.rd & host.cs;
  wire thr_wr = this_wr & a == A_DATA & !divisor_access_bit;
  wire fcr_wr = this_wr & a == A_ISR & !divisor_access_bit;
  wire rhr_rd = rd_go & a == A_DATA & !divisor_access_bit;
  wire mode1 = fifo_en & dma_sel;
  wire tx_full = fifo_en ? tx_count == FIFO_DEPTH : tx_count != 5'h0;
  wire rx_full = fifo_en ? rx_count == FIFO_DEPTH : rx_count != 5'h0;
  wire tx_push = thr_wr & !tx_full;
  wire tx_pop = tx_state == TX_IDLE & tx_count != 5'h0;
  wire rx_push = rx_done & !rx_full;
  wire rx_pop = rhr_rd & rx_count != 5'h0;
  wire tx_clr = fcr_wr & d[FCR_TXCLR];
  wire rx_clr = fcr_wr & d[FCR_RXCLR];
  wire at_trig = rx_count >= trig_level(trig);
  wire rx_timeout = to_cnt == to_limit;

  // Register writes; the divisor-access bit remaps the low addresses.
  always_ff @(posedge clk) begin
    if (reset) begin
      interrupt_enable <= 4'h0;
      line_format_reg <= 8'h00;
      dll <= 8'h00;
      dlm <= 8'h00;
      fifo_en <= 1'b0;
      dma_sel <= 1'b0;
      trig <= 2'h0;
      afr_mf <= 2'h0;
    end else if (this_wr) begin
      case (a)
        A_DATA: if (divisor_access_bit) dll <= d;
        A_IER: if (divisor_access_bit) dlm <= d; else interrupt_enable <= d[3:0];
        A_ISR: begin
          if (divisor_access_bit) begin
            afr_mf <= d[2:1];
          end else begin
            fifo_en <= d[FCR_EN];
            dma_sel <= d[FCR_DMA];
            trig <= d[7:6];
          end
        end
        A_LCR: line_format_reg <= d;
        default: ;
      endcase
    end
  end

  // The concurrent bit follows an alternate-register write through either channel.
  always_ff @(posedge clk) begin
    if (reset)
      concurrent_write <= 1'b0;
    else if (host.wr & (host.cs | host.peer_cs) & divisor_access_bit & a == A_ISR)
      concurrent_write <= d[0];
  end

  always_ff @(posedge clk) begin
    if (reset | divisor == 16'h0) begin
      baud_cnt <= 16'h0;
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= baud_cnt <= 16'h1;
      baud_cnt <= baud_cnt <= 16'h1 ? divisor : baud_cnt - 16'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (tx_push)
      txq[tx_wp] <= d;
    if (rx_push)
      rxq[rx_wp] <= rx_shift >> (4'h8 - wl);
  end

  always_ff @(posedge clk) begin
    if (reset | tx_clr) begin
      tx_wp <= 4'h0;
      tx_rp <= 4'h0;
      tx_count <= 5'h0;
    end else begin
      tx_wp <= tx_wp + {3'h0, tx_push};
      tx_rp <= tx_rp + {3'h0, tx_pop};
      tx_count <= tx_count + {4'h0, tx_push} - {4'h0, tx_pop};
    end
  end

  always_ff @(posedge clk) begin
    if (reset | rx_clr) begin
      rx_wp <= 4'h0;
      rx_rp <= 4'h0;
      rx_count <= 5'h0;
    end else begin
      rx_wp <= rx_wp + {3'h0, rx_push};
      rx_rp <= rx_rp + {3'h0, rx_pop};
      rx_count <= rx_count + {4'h0, rx_push} - {4'h0, rx_pop};
    end
  end

  always_comb begin
    if (!line_format_reg[STOP_BIT])
      stop_len = STOP_1;
    else
      stop_len = wl == WL_FIVE ? STOP_15 : STOP_2;
  end

  // Transmitter: start, wl data bits LSB first, stop; timed in 16x ticks.
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_state <= TX_IDLE;
      tx <= 1'b1;
      tx_cnt <= 6'h0;
      tx_bit <= 3'h0;
      tx_shift <= 8'h00;
    end else if (tx_pop) begin
      tx_shift <= txq[tx_rp];
      tx_state <= TX_START;
      tx_cnt <= 6'h0;
      tx <= 1'b0;
    end else if (baud_tick) begin
      tx_cnt <= tx_cnt + 6'h1;
      case (tx_state)
        TX_START: if (tx_cnt == BIT_LAST) begin
          tx_state <= TX_DATA;
          tx_cnt <= 6'h0;
          tx_bit <= 3'h0;
          tx <= tx_shift[0];
        end
        TX_DATA: if (tx_cnt == BIT_LAST) begin
          tx_cnt <= 6'h0;
          tx_shift <= tx_shift >> 1;
          tx_bit <= tx_bit + 3'h1;
          tx <= tx_shift[1];
          if ({1'b0, tx_bit} == wl - 4'h1) begin
            tx_state <= TX_STOP;
            tx <= 1'b1;
          end
        end
        TX_STOP: if (tx_cnt == stop_len - 6'h1) tx_state <= TX_IDLE;
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // Receiver: mid-bit sampling from the start edge, LSB first.
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_state <= RX_IDLE;
      rx_prev <= 1'b1;
      rx_cnt <= 6'h0;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
      rx_done <= 1'b0;
      rx_ferr <= 1'b0;
    end else begin
      rx_prev <= rx;
      rx_done <= 1'b0;
      if (rx_state == RX_IDLE) begin
        if (rx_prev & !rx) begin
          rx_state <= RX_START;
          rx_cnt <= 6'h0;
        end
      end else if (baud_tick) begin
        rx_cnt <= rx_cnt + 6'h1;
        case (rx_state)
          RX_START: if (rx_cnt == START_MID) begin
            rx_state <= rx ? RX_IDLE : RX_DATA;
            rx_cnt <= 6'h0;
            rx_bit <= 3'h0;
          end
          RX_DATA: if (rx_cnt == BIT_LAST) begin
            rx_cnt <= 6'h0;
            rx_shift <= {rx, rx_shift[7:1]};
            rx_bit <= rx_bit + 3'h1;
            if ({1'b0, rx_bit} == wl - 4'h1)
              rx_state <= RX_STOP;
          end
          RX_STOP: if (rx_cnt == BIT_LAST) begin
            rx_state <= RX_IDLE;
            rx_done <= 1'b1;
            rx_ferr <= !rx;
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end

  // Error flags; an event in the cycle of a status read is kept.
  always_ff @(posedge clk) begin
    if (reset) begin
      overrun <= 1'b0;
      ferr <= 1'b0;
    end else begin
      if (rd_go & a == A_LSR) begin
        overrun <= 1'b0;
        ferr <= 1'b0;
      end
      if (rx_done & rx_full)
        overrun <= 1'b1;
      if (rx_push & rx_ferr)
        ferr <= 1'b1;
    end
  end

  assign to_limit = ({2'h0, wl} << TO_SHIFT) + TO_ADD;

  // Timeout counts bit times, restarting at stop centre, on reads and while empty.
  always_ff @(posedge clk) begin
    if (reset) begin
      to_sub <= 4'h0;
      to_cnt <= 6'h0;
    end else begin
      if (baud_tick)
        to_sub <= to_sub + 4'h1;
      if (rx_done | rhr_rd | rx_count == 5'h0 | !fifo_en)
        to_cnt <= 6'h0;
      else if (baud_tick & to_sub == TICK_LAST & !rx_timeout)
        to_cnt <= to_cnt + 6'h1;
    end
  end

  // Transmit-empty source: set on emptying, cleared by a write or by reading it as reported.
  always_ff @(posedge clk) begin
    if (reset)
      thre_pend <= 1'b0;
    else if ((tx_pop & tx_count == 5'h1) | tx_clr | (this_wr & a == A_IER & !divisor_access_bit & d[1] & tx_count == 5'h0))
      thre_pend <= 1'b1;
    else if (thr_wr | (rd_go & a == A_ISR & !divisor_access_bit & isr_id == ID_THR & any_pend))
      thre_pend <= 1'b0;
  end

  always_comb begin
    ls_src = interrupt_enable[2] & (overrun | ferr);
    rda_src = interrupt_enable[0] & (fifo_en ? at_trig : rx_count != 5'h0);
    to_src = interrupt_enable[0] & fifo_en & rx_timeout & rx_count != 5'h0;
    thre_src = interrupt_enable[1] & thre_pend;
    ms_src = interrupt_enable[3] & modem_event;
    any_pend = ls_src | rda_src | to_src | thre_src | ms_src;
    if (ls_src) isr_id = ID_LS;
    else if (rda_src) isr_id = ID_RDA;
    else if (to_src) isr_id = ID_TO;
    else if (thre_src) isr_id = ID_THR;
    else isr_id = ID_MS;
    lsr_val = {fifo_en & ferr, tx_count == 5'h0 & tx_state == TX_IDLE, tx_count == 5'h0,
               1'b0, ferr, 1'b0, overrun, rx_count != 5'h0};
  end

  // Read data is registered and presented one cycle after the strobe.
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data <= 8'h00;
      rd_data_oe <= 1'b0;
    end else begin
      rd_data_oe <= rd_go;
      if (rd_go) begin
        case (a)
          A_DATA: rd_data <= divisor_access_bit ? dll : rxq[rx_rp];
          A_IER: rd_data <= divisor_access_bit ? dlm : {4'h0, interrupt_enable};
          A_ISR: rd_data <= divisor_access_bit ? {5'h00, afr_mf, concurrent_write} :
                            {fifo_en, fifo_en, 2'h0, isr_id, !any_pend};
          A_LCR: rd_data <= line_format_reg;
          A_LSR: rd_data <= lsr_val;
          default: rd_data <= 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset | rx_count == 5'h0)
      rx_dma_act <= 1'b0;
    else if (at_trig | rx_timeout)
      rx_dma_act <= 1'b1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      int_out <= 1'b0;
      tx_ready_n <= 1'b0;
      rx_ready_n <= 1'b1;
      multifunction_pin_n <= 1'b1;
    end else begin
      int_out <= any_pend;
      tx_ready_n <= mode1 ? tx_count == FIFO_DEPTH : tx_count != 5'h0;
      rx_ready_n <= mode1 ? !rx_dma_act : rx_count == 5'h0;
      case (afr_mf)
        MF_OP2: multifunction_pin_n <= general_output_two_n;
        MF_BAUD: multifunction_pin_n <= !baud_tick;
        MF_RX_READY_N: multifunction_pin_n <= rx_ready_n;
        default: multifunction_pin_n <= 1'b1;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_thr_accept: assert property (tx_push |=> tx_count != 5'h0 || tx_state != TX_IDLE)
    else $error("holding write lost");
  a_start_noise: assert property (rx_state == RX_START && baud_tick && rx_cnt == START_MID && rx
    |=> rx_state == RX_IDLE)
    else $error("noise start accepted");
  a_rda_trigger: assert property (fifo_en && interrupt_enable[0] && at_trig |=> int_out)
    else $error("trigger interrupt missing");
  a_data_ready: assert property (rx_push |=> lsr_val[0])
    else $error("data ready not set");
  a_baud_period: assert property (baud_tick && divisor == 16'h3 && !this_wr
    |=> !baud_tick [*2] ##1 baud_tick)
    else $error("baud period wrong");
  a_ier_gate: assert property (interrupt_enable == 4'h0 |=> !int_out)
    else $error("interrupt with sources masked");
  a_isr_priority: assert property (ls_src |-> isr_id == ID_LS)
    else $error("line status not highest");
  a_isr_fifo_bits: assert property (rd_go && a == A_ISR && !divisor_access_bit |=> rd_data[7:6] == {2{$past(fifo_en)}})
    else $error("ident upper bits wrong");
  a_fifo_flush: assert property (rx_clr |=> rx_count == 5'h0)
    else $error("receive flush failed");
  a_tx_ready_n_full: assert property (mode1 && tx_count == FIFO_DEPTH |=> tx_ready_n)
    else $error("transmit ready with full fifo");
  a_timeout_empty: assert property (rx_count == 5'h0 |-> !to_src)
    else $error("timeout while empty");

  c_rx_char: cover property (rx_push);
  c_timeout: cover property (to_src);
  c_tx_frame: cover property (tx_state == TX_STOP ##1 tx_state == TX_IDLE);
endmodule : ufc_channel

/* verilog/ufc_pkg.sv */
// Package for one serial channel with 16-byte FIFOs: addresses, codes, counts and bus struct.
// Assumes an 8-bit host register port and a 16x baud tick derived from clk.
package ufc_pkg;
  localparam logic [2:0] A_DATA = 3'h0;
  localparam logic [2:0] A_IER = 3'h1;
  localparam logic [2:0] A_ISR = 3'h2;
  localparam logic [2:0] A_LCR = 3'h3;
  localparam logic [2:0] A_LSR = 3'h5;
  localparam int DIVISOR_ACCESS_BIT_BIT = 7;
  localparam int STOP_BIT = 2;
  localparam int FCR_EN = 0;
  localparam int FCR_RXCLR = 1;
  localparam int FCR_TXCLR = 2;
  localparam int FCR_DMA = 3;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [3:0] WL_BASE = 4'h5;
  localparam logic [3:0] WL_FIVE = 4'h5;
  localparam logic [4:0] TRIG_1 = 5'h01;
  localparam logic [4:0] TRIG_4 = 5'h04;
  localparam logic [4:0] TRIG_8 = 5'h08;
  localparam logic [4:0] TRIG_14 = 5'h0e;
  // Identification codes as they sit in bits 3:1.
  localparam logic [2:0] ID_LS = 3'h3;
  localparam logic [2:0] ID_RDA = 3'h2;
  localparam logic [2:0] ID_TO = 3'h6;
  localparam logic [2:0] ID_THR = 3'h1;
  localparam logic [2:0] ID_MS = 3'h0;
  // Counts in 16x ticks; the timeout terms count bit times.
  localparam logic [5:0] BIT_LAST = 6'h0f;
  localparam logic [5:0] START_MID = 6'h07;
  localparam logic [5:0] STOP_1 = 6'h10;
  localparam logic [5:0] STOP_15 = 6'h18;
  localparam logic [5:0] STOP_2 = 6'h20;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [5:0] TO_ADD = 6'h0c;
  localparam int TO_SHIFT = 2;
  localparam logic [1:0] MF_OP2 = 2'h0;
  localparam logic [1:0] MF_BAUD = 2'h1;
  localparam logic [1:0] MF_RX_READY_N = 2'h2;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ufc_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ufc_rx_e;
  typedef struct packed {
    logic rd;
    logic wr;
    logic cs;
    logic peer_cs;
    logic [2:0] addr;
    logic [7:0] data;
  } ufc_host_s;
endpackage : ufc_pkg

/* testbench/ufc_line_peer.sv */
// Serial line peer: sends frames on rx and captures frames from tx.
// Assumes divisor 1, so one bit lasts sixteen clk cycles.
`timescale 1ns/1ps
module ufc_line_peer (
  input wire logic clk,
  input wire logic tx,
  output logic rx
);
  localparam int BIT_CLKS = 16;
  initial rx = 1'b1;
  task automatic hold(input logic v);
    @(posedge clk);
    rx <= v;
    repeat (BIT_CLKS - 1) @(posedge clk);
  endtask : hold
  // Start bit, data bits LSB first, one stop bit of the given level, then mark.
  task automatic send_frame(input logic [7:0] b, input int wl, input logic stop_lvl);
    hold(1'b0);
    for (int i = 0; i < wl; i++) hold(b[i]);
    hold(stop_lvl);
    @(posedge clk);
    rx <= 1'b1;
  endtask : send_frame
  // A low spike much shorter than half a bit.
  task automatic glitch();
    @(posedge clk);
    rx <= 1'b0;
    repeat (4) @(posedge clk);
    rx <= 1'b1;
  endtask : glitch
  // Samples each bit at its centre; a missing stop bit returns unknown.
  task automatic recv_frame(output logic [7:0] b, input int wl);
    b = 8'h00;
    do @(posedge clk); while (tx !== 1'b0);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < wl; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      b[i] = tx;
    end
    repeat (BIT_CLKS) @(posedge clk);
    if (tx !== 1'b1) b = 8'hxx;
  endtask : recv_frame
endmodule : ufc_line_peer

/* testbench/testbench.sv */
// Self-checking bench for one serial channel, driving registers and the serial line peer.
// Assumes ufc_pkg, ufc_channel and ufc_line_peer are compiled first.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin bad_count++; \
  $display("BAD %s expected %h seen %h", nm, ex, got); end end
module testbench;
  import ufc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  ufc_host_s host = '0;
  logic modem_event = 1'b0;
  logic general_output_two_n = 1'b1;
  logic rx, rd_data_oe, tx, int_out, tx_ready_n, rx_ready_n, multifunction_pin_n, concurrent_write;
  logic [7:0] rd_data;
  logic [7:0] d;
  int bad_count = 0;
  int comparisons = 0;
  always #12.5 clk = ~clk;
  ufc_channel ufc_channel_inst (.clk(clk), .reset(reset), .host(host), .rx(rx), .modem_event(modem_event),
    .general_output_two_n(general_output_two_n), .rd_data(rd_data), .rd_data_oe(rd_data_oe), .tx(tx),
    .int_out(int_out), .tx_ready_n(tx_ready_n), .rx_ready_n(rx_ready_n),
    .multifunction_pin_n(multifunction_pin_n), .concurrent_write(concurrent_write));
  ufc_line_peer peer (.clk(clk), .tx(tx), .rx(rx));
  task automatic wr(input logic [2:0] a, input logic [7:0] v, input logic to_peer = 1'b0);
    @(posedge clk);
    host <= '{rd: 1'b0, wr: 1'b1, cs: !to_peer, peer_cs: to_peer, addr: a, data: v};
    @(posedge clk);
    host <= '0;
  endtask : wr
  // A read without its data enable gives unknown, so it never matches.
  task automatic rc(input string nm, input logic [2:0] a, input logic [7:0] ex);
    @(posedge clk);
    host <= '{rd: 1'b1, wr: 1'b0, cs: 1'b1, peer_cs: 1'b0, addr: a, data: 8'h00};
    @(posedge clk);
    host <= '0;
    #1;
    d = rd_data_oe ? rd_data : 8'hxx;
    `CHK(nm, ex, d)
  endtask : rc
  task automatic t_reset();
    #1;
    `CHK("tx_ready_n reset", 1'b0, tx_ready_n)
    `CHK("rx_ready_n reset", 1'b1, rx_ready_n)
    rc("ident reset", A_ISR, 8'h01);
    rc("status reset", A_LSR, 8'h60);
  endtask : t_reset
  task automatic t_format();
    logic [7:0] b;
    wr(A_LCR, 8'h80);
    wr(A_DATA, 8'h01);
    wr(A_IER, 8'h00);
    rc("divisor low", A_DATA, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(A_LCR, 8'(i));
      rc("tx empty", A_LSR, 8'h60);
      fork
        peer.recv_frame(b, i + 5);
        wr(A_DATA, 8'h96);
      join
      `CHK("tx frame", 8'h96 & (8'hff >> (3 - i)), b)
      repeat (16) @(posedge clk);
    end
    `CHK("tx_ready_n idle", 1'b0, tx_ready_n)
    wr(A_IER, 8'hff);
    rc("enables", A_IER, 8'h0f);
    wr(A_IER, 8'h00);
  endtask : t_format
  task automatic t_rx();
    peer.glitch();
    repeat (200) @(posedge clk);
    rc("noise dropped", A_LSR, 8'h60);
    peer.send_frame(8'h3c, 8, 1'b1);
    repeat (4) @(posedge clk);
    `CHK("rx_ready_n held", 1'b0, rx_ready_n)
    rc("data ready", A_LSR, 8'h61);
    rc("rx byte", A_DATA, 8'h3c);
    rc("data gone", A_LSR, 8'h60);
    `CHK("rx_ready_n empty", 1'b1, rx_ready_n)
  endtask : t_rx
  task automatic t_trigger();
    int lvl[4] = '{1, 4, 8, 14};
    wr(A_IER, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr(A_ISR, {2'(k), 6'h03});
      for (int i = 1; i < lvl[k]; i++) peer.send_frame(8'(i), 8, 1'b1);
      repeat (4) @(posedge clk);
      `CHK("below trigger", 1'b0, int_out)
      peer.send_frame(8'h55, 8, 1'b1);
      repeat (4) @(posedge clk);
      `CHK("at trigger", 1'b1, int_out)
      rc("rda ident", A_ISR, 8'hc4);
      rc("oldest", A_DATA, (k == 0) ? 8'h55 : 8'h01);
      repeat (2) @(posedge clk);
      `CHK("below again", 1'b0, int_out)
      wr(A_ISR, {2'(k), 6'h03});
      rc("rx flushed", A_LSR, 8'h60);
    end
  endtask : t_trigger
  task automatic t_timeout();
    wr(A_ISR, 8'h8b);
    peer.send_frame(8'h11, 8, 1'b1);
    peer.send_frame(8'h22, 8, 1'b1);
    repeat (4) @(posedge clk);
    `CHK("rx_ready_n below", 1'b1, rx_ready_n)
    repeat (41 * 16) @(posedge clk);
    rc("no timeout yet", A_ISR, 8'hc1);
    repeat (5 * 16) @(posedge clk);
    rc("timeout ident", A_ISR, 8'hcc);
    `CHK("rx_ready_n timeout", 1'b0, rx_ready_n)
    rc("first", A_DATA, 8'h11);
    rc("second", A_DATA, 8'h22);
    repeat (3) @(posedge clk);
    `CHK("rx_ready_n drained", 1'b1, rx_ready_n)
    rc("empty no timeout", A_ISR, 8'hc1);
  endtask : t_timeout
  task automatic t_txfull();
    logic [7:0] b;
    wr(A_ISR, 8'h0d);
    fork
      peer.recv_frame(b, 8);
      begin
        wr(A_DATA, 8'h71);
        repeat (4) @(posedge clk);
        for (int i = 0; i < 16; i++) wr(A_DATA, 8'(i));
        repeat (2) @(posedge clk);
        `CHK("tx_ready_n full", 1'b1, tx_ready_n)
        rc("tx fifo full", A_LSR, 8'h00);
        wr(A_ISR, 8'h0d);
        repeat (2) @(posedge clk);
        `CHK("tx_ready_n free", 1'b0, tx_ready_n)
        rc("tx flushed", A_LSR, 8'h20);
      end
    join
    `CHK("shifter kept", 8'h71, b)
    repeat (16) @(posedge clk);
  endtask : t_txfull
  task automatic t_afr();
    wr(A_LCR, 8'h83);
    wr(A_ISR, 8'h01);
    rc("afr read", A_ISR, 8'h01);
    `CHK("concurrent on", 1'b1, concurrent_write)
    wr(A_ISR, 8'h05, 1'b1);
    rc("peer write", A_ISR, 8'h05);
    wr(A_ISR, 8'h03, 1'b1);
    repeat (3) @(posedge clk);
    `CHK("mf baud", 1'b0, multifunction_pin_n)
    wr(A_ISR, 8'h05, 1'b1);
    @(posedge clk) general_output_two_n <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("mf rx_ready_n", 1'b1, multifunction_pin_n)
    wr(A_ISR, 8'h01, 1'b1);
    repeat (3) @(posedge clk);
    `CHK("mf out two", 1'b0, multifunction_pin_n)
    wr(A_ISR, 8'h00, 1'b1);
    repeat (2) @(posedge clk);
    `CHK("concurrent off", 1'b0, concurrent_write)
    wr(A_LCR, 8'h80, 1'b1);
    rc("peer ignored", A_LCR, 8'h83);
    wr(A_LCR, 8'h03);
    @(posedge clk) general_output_two_n <= 1'b1;
  endtask : t_afr
  task automatic t_prio();
    wr(A_ISR, 8'h06);
    wr(A_IER, 8'h0f);
    @(posedge clk) modem_event <= 1'b1;
    rc("thr over modem", A_ISR, 8'h02);
    `CHK("int pending", 1'b1, int_out)
    rc("modem after thr", A_ISR, 8'h00);
    peer.send_frame(8'h5a, 8, 1'b0);
    repeat (4) @(posedge clk);
    rc("line status top", A_ISR, 8'h06);
    rc("framing", A_LSR, 8'h69);
    rc("rda next", A_ISR, 8'h04);
    rc("bad byte", A_DATA, 8'h5a);
    rc("modem last", A_ISR, 8'h00);
    @(posedge clk) modem_event <= 1'b0;
    repeat (3) @(posedge clk);
    rc("none pending", A_ISR, 8'h01);
    `CHK("int idle", 1'b0, int_out)
  endtask : t_prio
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_format();
    t_rx();
    t_trigger();
    t_timeout();
    t_txfull();
    t_afr();
    t_prio();
    complete_run();
  end
endmodule : testbench
